// *** dv/crh_host_model.sv ***
// Host controller model: paces bit times and confirms transmissions
`timescale 1ns/1ps
module crh_host_model (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic tx_valid,
    input  wire logic slow,
    output logic      tx_done,
    output logic      bit_tick
);
    int tick_cnt = 0;
    int busy_cnt = 0;
    initial tx_done = 1'b0;
    initial bit_tick = 1'b0;
    // One bus bit time every four clocks
    always @(negedge sys_clk) begin
        tick_cnt <= (tick_cnt + 1) % 4;
        bit_tick <= (tick_cnt == 3);
    end
    // Confirm a pending frame after a short or a long bus time
    always @(negedge sys_clk) begin
        tx_done <= 1'b0;
        if (sys_rst || !tx_valid || tx_done) begin
            busy_cnt <= 0;
        end else if (busy_cnt == (slow ? 12 : 2)) begin
            tx_done <= 1'b1;
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the remote I/O frame handler
`timescale 1ns/1ps
module tb;
    import crh_pkg::*;
    logic        sys_clk, sys_rst, id_strap_bit3, rx_valid, rx_ready, rx_ide;
    logic        rx_rtr, rx_calib, tx_valid, tx_rtr, tx_done, bit_tick;
    logic        calib_done, error_warn_flag, bus_mode_hi, bus_mode_lo;
    logic        bus_err_cond, bus_ovl_cond, err_frame_req, ovl_frame_req;
    logic        cal_ack, adc_start, adc_done, slow;
    logic [2:0]  id_strap_low_bits, analog_switch_select;
    logic [10:0] rx_id, tx_id;
    logic [3:0]  rx_dlc, tx_dlc;
    logic [7:0]  rx_data0, rx_data1, rx_data2;
    logic [23:0] tx_data, rd;
    logic [15:0] data_in, adc_result;
    int          err_count, checks, cnt;

    crh_frame_handler i_crh_frame_handler (.sys_clk, .sys_rst,
        .id_strap_bit3, .id_strap_low_bits, .rx_valid, .rx_ready, .rx_ide,
        .rx_rtr, .rx_calib, .rx_id, .rx_dlc, .rx_data0, .rx_data1,
        .rx_data2, .tx_valid, .tx_id, .tx_rtr, .tx_dlc, .tx_data, .tx_done,
        .bit_tick, .calib_done, .error_warn_flag, .bus_mode_hi,
        .bus_mode_lo, .bus_err_cond, .bus_ovl_cond, .err_frame_req,
        .ovl_frame_req, .cal_ack, .data_in, .adc_start, .adc_done,
        .adc_result, .analog_switch_select);
    crh_host_model i_crh_host_model (.sys_clk, .sys_rst, .tx_valid, .slow,
        .tx_done, .bit_tick);

    // Clock at 125 MHz
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Watchdog cuts a hang short
    initial begin
        #400000;
        err_count++;
        give_verdict();
    end

    task chk(string n, logic [23:0] seen, logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task give_verdict();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Identifier built from the straps latched at reset (bit3=1, low=010)
    function automatic logic [10:0] nid(logic dir);
        return {2'b01, 1'b1, 2'b10, 3'b010, 2'b10, dir};
    endfunction
    // Offer one frame and hold it until the handler takes it
    task send(logic ide, rtr, cal, logic [10:0] id, logic [3:0] dlc,
              logic [23:0] d);
        @(negedge sys_clk);
        {rx_ide, rx_rtr, rx_calib, rx_id, rx_dlc} = {ide, rtr, cal, id, dlc};
        {rx_data0, rx_data1, rx_data2} = d;
        rx_valid = 1'b1;
        for (int n = 0; n < 20 && rx_ready !== 1'b1; n++) @(negedge sys_clk);
        @(negedge sys_clk);
        rx_valid = 1'b0;
    endtask
    // Wait for a reply frame, check its header and return its data
    task get(output logic [23:0] d);
        for (int n = 0; n < 300 && tx_valid !== 1'b1; n++) @(negedge sys_clk);
        chk("tx_valid", tx_valid, 1);
        chk("tx_id", tx_id, nid(1));
        chk("tx_dlc", tx_dlc, 3);
        chk("tx_rtr", tx_rtr, 0);
        d = tx_data;
        for (int n = 0; n < 300 && tx_valid === 1'b1; n++) @(negedge sys_clk);
    endtask
    task quiet(int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge sys_clk);
            seen |= tx_valid;
        end
        chk("no reply", seen, 0);
    endtask
    task wait_start();
        for (int n = 0; n < 8 && adc_start !== 1'b1; n++) @(negedge sys_clk);
        chk("adc_start", adc_start, 1);
    endtask
    task pulse_adc(logic [15:0] v);
        @(negedge sys_clk);
        {adc_done, adc_result} = {1'b1, v};
        @(negedge sys_clk);
        adc_done = 1'b0;
    endtask

    // Back-to-back writes, reply contents and transmit spacing
    task t_write();
        send(0, 0, 0, nid(0), 3, 24'h03a55a);
        send(0, 0, 0, nid(0), 3, 24'h091234);
        get(rd);
        chk("write reply", rd, 24'h63a55a);
        cnt = 0;
        for (int n = 0; n < 300 && tx_valid !== 1'b1; n++) begin
            @(negedge sys_clk);
            cnt += bit_tick;
        end
        chk("hold ticks", cnt >= 3, 1);
        get(rd);
        chk("reserved reply", rd, 24'h690000);
    endtask
    // Frames that must be passed over silently
    task t_reject();
        send(1, 0, 0, nid(0), 3, 24'h03ffff);
        send(0, 0, 0, nid(1), 3, 24'h03ffff);
        send(0, 0, 0, nid(0) ^ 11'h100, 3, 24'h03ffff);
        send(0, 0, 0, nid(0), 4, 24'h03ffff);
        send(0, 0, 0, nid(0), 2, 24'h03ffff);
        send(0, 1, 0, nid(1), 2, 24'h000000);
        quiet(40);
    endtask
    // Remote frame answered slowly with the data input register
    task t_remote();
        slow = 1'b1;
        send(0, 1, 0, nid(1), 3, 24'h000000);
        get(rd);
        chk("remote reply", rd, {8'h60, data_in});
        slow = 1'b0;
    endtask
    // Conversions started by frame and by start bit
    task t_adc();
        send(0, 0, 0, nid(0), 3, 24'h08ffff);
        wait_start();
        quiet(20);
        pulse_adc(16'h0bcd);
        get(rd);
        chk("result reply", rd, 24'h680bcd);
        send(0, 0, 0, nid(0), 3, 24'h058005);
        wait_start();
        @(negedge sys_clk);
        chk("switch", analog_switch_select, 3'b101);
        get(rd);
        chk("config reply", rd[23:16], 8'h65);
        pulse_adc(16'h0321);
        get(rd);
        chk("second result", rd, 24'h680321);
    endtask
    // Calibration frames, sign-on and the calibrated flag
    task t_calib();
        logic [3:0] dl[3] = '{4'h2, 4'h8, 4'h9};
        logic       ack;
        foreach (dl[i]) begin
            send(0, 0, 1, nid(0), dl[i], 24'h000000);
            ack = 1'b0;
            repeat (3) begin
                ack |= cal_ack;
                @(negedge sys_clk);
            end
            chk("cal_ack", ack, dl[i] != 4'h9);
        end
        quiet(20);
        @(negedge sys_clk);
        calib_done = 1'b1;
        @(negedge sys_clk);
        calib_done = 1'b0;
        get(rd);
        chk("sign-on", rd, {8'he0, data_in});
        send(0, 0, 0, nid(0), 3, 24'h030042);
        get(rd);
        chk("after sign-on", rd, 24'h630042);
    endtask
    // Error and overload requests follow bus conditions only
    task t_bus();
        chk("ovl idle", ovl_frame_req, 0);
        bus_err_cond = 1'b1;
        @(negedge sys_clk);
        chk("err req", err_frame_req, 1);
        {bus_err_cond, bus_ovl_cond} = 2'b01;
        @(negedge sys_clk);
        chk("ovl req", {err_frame_req, ovl_frame_req}, 2'b01);
        bus_ovl_cond = 1'b0;
        @(negedge sys_clk);
        chk("ovl drop", ovl_frame_req, 0);
    endtask

    // Main sequence: straps change after reset to show they were latched
    initial begin
        {sys_rst, id_strap_bit3, id_strap_low_bits} = {1'b1, 1'b1, 3'b010};
        {rx_valid, rx_ide, rx_rtr, rx_calib, rx_id, rx_dlc} = '0;
        {rx_data0, rx_data1, rx_data2, calib_done, slow} = '0;
        {error_warn_flag, bus_mode_hi, bus_mode_lo} = 3'b110;
        {bus_err_cond, bus_ovl_cond, adc_done, adc_result} = '0;
        data_in = 16'hc3e1;
        err_count = 0;
        checks = 0;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("rx_ready", rx_ready, 1);
        {id_strap_bit3, id_strap_low_bits} = 4'h0;
        t_write();
        t_reject();
        t_remote();
        t_adc();
        t_calib();
        t_bus();
        give_verdict();
    end
endmodule

// *** rtl/crh_frame_handler.sv ***
// Reply FIFO and the message-level frame handler of the remote I/O node
`timescale 1ns/1ps

module crh_fifo #(
    parameter int W = 24,
    parameter int D = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic          push, pop;

    // Handshakes; full and empty come from the fill count
    assign in_ready  = (count_reg != (AW+1)'(D));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(D-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(D-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module crh_frame_handler
    import crh_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        id_strap_bit3,
    input  wire logic [2:0]  id_strap_low_bits,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic        rx_ide,
    input  wire logic        rx_rtr,
    input  wire logic        rx_calib,
    input  wire logic [10:0] rx_id,
    input  wire logic [3:0]  rx_dlc,
    input  wire logic [7:0]  rx_data0,
    input  wire logic [7:0]  rx_data1,
    input  wire logic [7:0]  rx_data2,
    output logic             tx_valid,
    output logic [10:0]      tx_id,
    output logic             tx_rtr,
    output logic [3:0]       tx_dlc,
    output logic [23:0]      tx_data,
    input  wire logic        tx_done,
    input  wire logic        bit_tick,
    input  wire logic        calib_done,
    input  wire logic        error_warn_flag,
    input  wire logic        bus_mode_hi,
    input  wire logic        bus_mode_lo,
    input  wire logic        bus_err_cond,
    input  wire logic        bus_ovl_cond,
    output logic             err_frame_req,
    output logic             ovl_frame_req,
    output logic             cal_ack,
    input  wire logic [15:0] data_in,
    output logic             adc_start,
    input  wire logic        adc_done,
    input  wire logic [15:0] adc_result,
    output logic [2:0]       analog_switch_select
);
    logic [15:0]   io_regs [1:REG_LAST];
    logic [15:0]   conv_result_reg, pend_data_reg, wr_val, reply_val;
    logic [9:0]    node_id_reg;
    logic [7:0]    pend_head_reg;
    logic [3:0]    wr_addr, status;
    logic [2:0]    sw_sel_reg, ticks_since;
    logic [1:0]    hold_cnt_reg;
    logic [23:0]   tx_data_reg, fifo_in_data, fifo_out_data;
    crh_tx_state_t tx_state_reg;
    logic          id_latched_reg, rx_ready_reg, rx_pend_reg, conv_pend_reg;
    logic          sign_pend_reg, calibrated_flag, adc_start_reg, cal_ack_reg;
    logic          err_req_reg, ovl_req_reg, tx_valid_reg, tx_finish;
    logic          std_take, acc_data, acc_rem, acc_cal, start_conv;
    logic          push_rx, push_conv, push_sign, fifo_in_valid, sent_once;
    logic          fifo_in_ready, fifo_out_valid, fifo_out_ready;

    // Frame classification; the node id carries the fixed and strap bits
    assign std_take = rx_valid && rx_ready_reg && !rx_ide;
    assign acc_data = std_take && !rx_rtr && !rx_calib
                   && rx_id == {node_id_reg, 1'b0}
                   && rx_dlc == DLC_REG;
    assign acc_rem  = std_take && rx_rtr
                   && rx_id == {node_id_reg, 1'b1}
                   && rx_dlc == DLC_REG;
    assign acc_cal  = std_take && !rx_rtr && rx_calib
                   && rx_dlc >= DLC_CAL_MIN
                   && rx_dlc <= DLC_CAL_MAX;
    assign wr_addr  = rx_data0[3:0];
    assign wr_val   = {rx_data1, rx_data2};
    assign status   = {calibrated_flag, error_warn_flag,
                       bus_mode_hi, bus_mode_lo};
    assign start_conv = acc_data && (wr_addr == ADDR_CONV
                     || (wr_addr == ADDR_ANA_CFG
                         && wr_val[CFG_START_POS]));
    assign tx_finish = (tx_state_reg == CRH_TX_SEND) && tx_done;

    // New contents of the addressed register, as the reply reports them
    always_comb begin
        reply_val = REG_RST;
        if (wr_addr == ADDR_DATA_IN) begin
            reply_val = data_in;
        end else if (wr_addr == ADDR_CONV) begin
            reply_val = conv_result_reg;
        end else if (wr_addr <= 4'(REG_LAST)) begin
            reply_val = wr_val;
        end
    end

    // Identifier straps caught in the first cycle after reset release
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            node_id_reg    <= ID_FIXED[10:1];
            id_latched_reg <= 1'b0;
        end else if (!id_latched_reg) begin
            id_latched_reg <= 1'b1;
            node_id_reg[ID_S3_POS-1] <= id_strap_bit3;
            node_id_reg[ID_SLO_POS-1 +: 3] <= id_strap_low_bits;
        end
    end

    // Writable port registers; start bit drops when conversion ends
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 1; i <= REG_LAST; i++) begin
                io_regs[i] <= REG_RST;
            end
        end else begin
            if (adc_done) begin
                io_regs[ADDR_ANA_CFG][CFG_START_POS] <= 1'b0;
            end
            if (acc_data && wr_addr != ADDR_DATA_IN
                && wr_addr <= 4'(REG_LAST)) begin
                io_regs[wr_addr[2:0]] <= wr_val;
            end
        end
    end

    // Conversion result holds the selected pin level, read only
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_result_reg <= REG_RST;
            adc_start_reg   <= 1'b0;
            sw_sel_reg      <= '0;
        end else begin
            adc_start_reg <= start_conv;
            sw_sel_reg    <= io_regs[ADDR_ANA_CFG][CFG_SW_LSB +: CFG_SW_W];
            if (adc_done) begin
                conv_result_reg <= adc_result;
            end
        end
    end

    // Reply pending from a received frame, address kept until queued
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_pend_reg   <= 1'b0;
            rx_ready_reg  <= 1'b0;
            pend_head_reg <= '0;
            pend_data_reg <= REG_RST;
        end else begin
            rx_ready_reg <= id_latched_reg && !(rx_pend_reg && !push_rx)
                         && !acc_rem && !(acc_data && wr_addr != ADDR_CONV);
            if (acc_data && wr_addr != ADDR_CONV) begin
                rx_pend_reg   <= 1'b1;
                pend_head_reg <= {4'h0, wr_addr};
                pend_data_reg <= reply_val;
            end else if (acc_rem) begin
                rx_pend_reg   <= 1'b1;
                pend_head_reg <= {4'h0, ADDR_DATA_IN};
                pend_data_reg <= data_in;
            end else if (push_rx) begin
                rx_pend_reg <= 1'b0;
            end
        end
    end

    // Deferred conversion reply and sign-on reply; set wins over clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_pend_reg   <= 1'b0;
            sign_pend_reg   <= 1'b0;
            calibrated_flag <= 1'b0;
        end else begin
            conv_pend_reg <= adc_done || (conv_pend_reg && !push_conv);
            sign_pend_reg <= calib_done || (sign_pend_reg && !push_sign);
            calibrated_flag <= calib_done
                            || (calibrated_flag && !tx_finish);
        end
    end

    // Queue arbitration: received frame first, then conversion, then sign-on
    always_comb begin
        push_rx   = rx_pend_reg && fifo_in_ready;
        push_conv = conv_pend_reg && fifo_in_ready && !rx_pend_reg;
        push_sign = sign_pend_reg && fifo_in_ready && !rx_pend_reg
                 && !conv_pend_reg;
        fifo_in_valid = rx_pend_reg || conv_pend_reg || sign_pend_reg;
        if (rx_pend_reg) begin
            fifo_in_data = {status, pend_head_reg[3:0], pend_data_reg};
        end else if (conv_pend_reg) begin
            fifo_in_data = {status, ADDR_CONV, conv_result_reg};
        end else begin
            fifo_in_data = {status, ADDR_DATA_IN, data_in};
        end
    end

    crh_fifo #(
        .W (FIFO_W),
        .D (FIFO_DEPTH)
    ) u_reply_fifo (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = (tx_state_reg == CRH_TX_IDLE);

    // Transmit stage with three-bit-time hold-off after each success
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state_reg <= CRH_TX_IDLE;
            tx_valid_reg <= 1'b0;
            tx_data_reg  <= '0;
            hold_cnt_reg <= '0;
        end else begin
            case (tx_state_reg)
                CRH_TX_IDLE: begin
                    if (fifo_out_valid) begin
                        tx_valid_reg <= 1'b1;
                        tx_data_reg  <= fifo_out_data;
                        tx_state_reg <= CRH_TX_SEND;
                    end
                end
                CRH_TX_SEND: begin
                    if (tx_done) begin
                        tx_valid_reg <= 1'b0;
                        hold_cnt_reg <= '0;
                        tx_state_reg <= CRH_TX_HOLD;
                    end
                end
                CRH_TX_HOLD: begin
                    if (bit_tick) begin
                        hold_cnt_reg <= hold_cnt_reg + 1'b1;
                        if (hold_cnt_reg == HOLD_BITS - 2'h1) begin
                            tx_state_reg <= CRH_TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_reg <= CRH_TX_IDLE;
                end
            endcase
        end
    end

    // Error and overload requests follow bus conditions only
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_req_reg <= 1'b0;
            ovl_req_reg <= 1'b0;
            cal_ack_reg <= 1'b0;
        end else begin
            err_req_reg <= bus_err_cond;
            ovl_req_reg <= bus_ovl_cond;
            cal_ack_reg <= acc_cal;
        end
    end

    // Outputs straight from flip-flops or constant frame fields
    assign rx_ready             = rx_ready_reg;
    assign tx_valid             = tx_valid_reg;
    assign tx_data              = tx_data_reg;
    assign tx_id                = {node_id_reg, 1'b1};
    assign tx_rtr               = 1'b0;
    assign tx_dlc               = DLC_REG;
    assign adc_start            = adc_start_reg;
    assign err_frame_req        = err_req_reg;
    assign ovl_frame_req        = ovl_req_reg;
    assign cal_ack              = cal_ack_reg;
    assign analog_switch_select = sw_sel_reg;

    // Helper: bit ticks seen since the last successful transmission
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ticks_since <= '0;
            sent_once   <= 1'b0;
        end else if (tx_finish) begin
            ticks_since <= '0;
            sent_once   <= 1'b1;
        end else if (bit_tick && ticks_since != 3'h7) begin
            ticks_since <= ticks_since + 3'h1;
        end
    end

    AST_HOLDOFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(tx_valid_reg) && sent_once |-> ticks_since >= 3'h3)
        else $error("Transmission started inside hold-off");
    AST_TX_FORMAT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tx_valid |-> tx_id[0] && tx_dlc == 4'h3 && !tx_rtr)
        else $error("Transmitted frame has wrong direction or length");
    AST_TX_ID: assert property (@(posedge sys_clk) disable iff (sys_rst)
        id_latched_reg |-> (tx_id & 11'h6c6) == 11'h284)
        else $error("Fixed identifier bits are wrong");
    AST_CONV_START: assert property (@(posedge sys_clk) disable iff (sys_rst)
        acc_data && wr_addr == 4'h8 |=> adc_start && !rx_pend_reg)
        else $error("Result access did not start a conversion");
    AST_EXT_IGNORE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rx_valid && rx_ready && rx_ide && !rx_pend_reg && !adc_done
        |=> !rx_pend_reg && $stable(io_regs[5]))
        else $error("Extended frame was processed");
    AST_REPLY_ADDR: assert property (@(posedge sys_clk) disable iff (sys_rst)
        acc_data && wr_addr != 4'h8
        |=> rx_pend_reg && pend_head_reg[3:0] == $past(rx_data0[3:0]))
        else $error("Reply lost the received address");
    AST_REMOTE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        acc_rem |=> pend_head_reg[3:0] == 4'h0
                    && pend_data_reg == $past(data_in))
        else $error("Remote frame answer is not the data input");
    AST_RESULT_RO: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(adc_done) |-> $stable(conv_result_reg))
        else $error("Conversion result changed without a conversion");
    AST_STRAP_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        id_latched_reg && $past(id_latched_reg) |-> $stable(node_id_reg))
        else $error("Identifier latch changed after reset");
    AST_CAL_CLEAR: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tx_finish && !calib_done |=> !calibrated_flag)
        else $error("Calibrated flag survived a transmission");
endmodule

// *** rtl/crh_pkg.sv ***
// Constants and types shared by the remote I/O frame handler
package crh_pkg;
    localparam logic [3:0]  ADDR_DATA_IN = 4'h0;
    localparam logic [3:0]  ADDR_ANA_CFG = 4'h5;
    localparam logic [3:0]  ADDR_CONV    = 4'h8;
    localparam int          REG_LAST     = 7;
    localparam logic [3:0]  DLC_REG      = 4'h3;
    localparam logic [3:0]  DLC_CAL_MIN  = 4'h2;
    localparam logic [3:0]  DLC_CAL_MAX  = 4'h8;
    localparam int          CFG_START_POS = 15;
    localparam int          CFG_SW_LSB   = 0;
    localparam int          CFG_SW_W     = 3;
    localparam logic [15:0] REG_RST      = 16'h0000;
    localparam logic [10:0] ID_FIXED     = 11'h284;
    localparam int          ID_S3_POS    = 8;
    localparam int          ID_SLO_POS   = 3;
    localparam logic [1:0]  HOLD_BITS    = 2'h3;
    localparam int          FIFO_DEPTH   = 4;
    localparam int          FIFO_W       = 24;
    typedef enum logic [1:0] {
        CRH_TX_IDLE = 2'b00,
        CRH_TX_SEND = 2'b01,
        CRH_TX_HOLD = 2'b11
    } crh_tx_state_t;
endpackage
